// >>> src/fsp_pkg.sv
// Purpose: shared constants and types for the flash sector protection block
// Assumes: 16-bit flash array addresses, 8-bit protection setting
// Notes: zone masks let two settings be compared as sets of protected space
package fsp_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_SETTING = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int STAT_VIOL_BIT = 0;
  localparam int STAT_LOADED_BIT = 1;

  // ---------------------------------------------------------------
  // nonvolatile source and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] NV_PROT_ADDR = 16'hFF0D;
  // protects nothing; commands are held off until the nonvolatile byte has arrived
  localparam logic [7:0] SETTING_RESET = 8'hFF;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // protection setting field layout, bit 7 down to bit 0
  // ---------------------------------------------------------------
  typedef struct packed {
    logic protectPolaritySelect;
    logic spareNonvolatileFlag;
    logic upperRangeDisable;
    logic [1:0] upperRangeSize;
    logic lowerRangeDisable;
    logic [1:0] lowerRangeSize;
  } fsp_setting_type;

  // ---------------------------------------------------------------
  // commands from the flash command controller
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_PROGRAM = 2'h0,
    CMD_SECTOR_ERASE = 2'h1,
    CMD_MASS_ERASE = 2'h2,
    CMD_OTHER = 2'h3
  } fsp_cmd_kind_type;

  typedef struct packed {
    fsp_cmd_kind_type kind;
    logic [15:0] addr;
  } fsp_cmd_type;

  // ---------------------------------------------------------------
  // zones: 0..3 upper granules from the top, 4..7 lower granules
  // from 0x4000 upward, 8 everything else
  // ---------------------------------------------------------------
  localparam int ZONE_COUNT = 9;
  localparam logic [15:0] UPPER_START [4] =
    '{16'hF800, 16'hF000, 16'hE000, 16'hC000};
  localparam logic [15:0] LOWER_START = 16'h4000;
  localparam logic [15:0] LOWER_END [4] =
    '{16'h43FF, 16'h47FF, 16'h4FFF, 16'h5FFF};

  // protected zones implied by one setting
  function automatic logic [8:0] prot_mask(input fsp_setting_type s);
    logic [3:0] upWin;
    logic [3:0] loWin;
    logic [8:0] win;
    upWin = 4'h0;
    loWin = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      upWin[i] = (2'(i) <= s.upperRangeSize) & ~s.upperRangeDisable;
      loWin[i] = (2'(i) <= s.lowerRangeSize) & ~s.lowerRangeDisable;
    end
    win = {1'b0, loWin, upWin};
    // polarity one: windows are protected; zero: windows are the holes
    prot_mask = s.protectPolaritySelect ? win : ~win;
  endfunction

endpackage

// >>> src/fsp_prot_check.sv
// Purpose: decides whether one array address lies in protected space
// Assumes: protMask built by fsp_pkg::prot_mask
// Notes: purely combinational so the verdict is ready in the accept cycle
`timescale 1ns/10ps
module fsp_prot_check
(
  input wire logic [8:0] protMask,
  input wire logic [15:0] addr,
  output logic protectedHit
);

  logic [8:0] zone;

  // ---------------------------------------------------------------
  // address to one-hot zone
  // ---------------------------------------------------------------
  always_comb
  begin
    zone = 9'h000;
    if (addr >= fsp_pkg::UPPER_START[0])
      zone[0] = 1'b1;
    else if (addr >= fsp_pkg::UPPER_START[1])
      zone[1] = 1'b1;
    else if (addr >= fsp_pkg::UPPER_START[2])
      zone[2] = 1'b1;
    else if (addr >= fsp_pkg::UPPER_START[3])
      zone[3] = 1'b1;
    else if (addr < fsp_pkg::LOWER_START)
      zone[8] = 1'b1;
    else if (addr <= fsp_pkg::LOWER_END[0])
      zone[4] = 1'b1;
    else if (addr <= fsp_pkg::LOWER_END[1])
      zone[5] = 1'b1;
    else if (addr <= fsp_pkg::LOWER_END[2])
      zone[6] = 1'b1;
    else if (addr <= fsp_pkg::LOWER_END[3])
      zone[7] = 1'b1;
    else
      zone[8] = 1'b1;
  end

  assign protectedHit = |(zone & protMask);

endmodule

// >>> src/flash_sector_protection.sv
// Purpose: flash sector protection setting, write limits and violation check
// Assumes: single 200 MHz clock; array read port and command controller on it
// Notes: Avalon-MM slave answers one cycle after the request is seen
`timescale 1ns/10ps
module flash_sector_protection
(
  input wire logic sys_clk,
  input wire logic rstn,
  // Avalon-MM register slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  // flash array read port for the reset-time load
  output logic arrRdReq,
  output logic [15:0] arrRdAddr,
  input wire logic [7:0] arrRdData,
  input wire logic arrRdValid,
  // command requests from the flash command controller
  input wire logic cmdValid,
  input wire fsp_pkg::fsp_cmd_type cmdReq,
  output logic cmdReady,
  output logic cmdGrant,
  output logic cmdDeny,
  // state seen by the rest of the flash module
  output fsp_pkg::fsp_setting_type protectSetting,
  output logic protectViolation
);

  // ---------------------------------------------------------------
  // load sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN = 2'b01
  } fsp_state_type;

  fsp_state_type state_ff;
  fsp_state_type nxt_state;
  logic loaded;
  logic loadStrobe;

  assign loaded = (state_ff == ST_RUN);
  // a late array answer after the load is ignored
  assign loadStrobe = (state_ff == ST_LOAD) & arrRdValid;

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_LOAD:
      begin
        if (arrRdValid)
          nxt_state = ST_RUN;
      end
      ST_RUN:
      begin
        nxt_state = ST_RUN;
      end
      default:
      begin
        nxt_state = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      state_ff <= ST_LOAD;
    else
      state_ff <= nxt_state;
  end

  // request held until the array answers
  assign arrRdReq = (state_ff == ST_LOAD);
  assign arrRdAddr = fsp_pkg::NV_PROT_ADDR;

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  logic ack_ff;
  logic busReq;
  logic busWrite;
  logic busRead;
  logic hitSetting;
  logic hitStatus;

  // registered answer trades one cycle of latency for clean timing
  assign busReq = (avsRead | avsWrite) & loaded;
  assign avsWaitRequest = ~ack_ff;
  assign busWrite = avsWrite & ack_ff;
  assign busRead = avsRead & ~ack_ff;
  assign hitSetting = (avsAddress == fsp_pkg::ADDR_SETTING);
  assign hitStatus = (avsAddress == fsp_pkg::ADDR_STATUS);

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      ack_ff <= 1'b0;
    else
      ack_ff <= busReq & ~ack_ff;
  end

  // ---------------------------------------------------------------
  // protection setting write filter
  // ---------------------------------------------------------------
  fsp_pkg::fsp_setting_type setting_ff;
  fsp_pkg::fsp_setting_type candidate;
  fsp_pkg::fsp_setting_type wrBits;
  logic [8:0] curMask;
  logic [8:0] candMask;
  logic tightens;
  logic settingWrite;
  logic settingCommit;
  logic polarityKeep;
  logic upperSizeOpen;
  logic lowerSizeOpen;

  assign wrBits = avsWriteData[7:0];
  assign settingWrite = busWrite & hitSetting & avsByteEnable[0];

  // field limits judged on the value held before the write
  assign polarityKeep = setting_ff.protectPolaritySelect &
    wrBits.protectPolaritySelect;
  assign upperSizeOpen = setting_ff.upperRangeDisable;
  assign lowerSizeOpen = setting_ff.lowerRangeDisable;

  // spare flag bit stays as loaded; software cannot move it
  always_comb
  begin
    candidate = setting_ff;
    // polarity can only drop to zero
    candidate.protectPolaritySelect = polarityKeep;
    candidate.upperRangeDisable = wrBits.upperRangeDisable;
    candidate.lowerRangeDisable = wrBits.lowerRangeDisable;
    if (upperSizeOpen)
      candidate.upperRangeSize = wrBits.upperRangeSize;
    if (lowerSizeOpen)
      candidate.lowerRangeSize = wrBits.lowerRangeSize;
  end

  // protected zones per polarity, disable bits and sizes
  assign curMask =
    fsp_pkg::prot_mask(setting_ff);
  assign candMask = fsp_pkg::prot_mask(candidate);
  // accepted only if every zone protected now stays protected
  assign tightens = ((candMask & curMask) == curMask);
  // a rejected write leaves every field as it was, not just some
  assign settingCommit = settingWrite & tightens;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      setting_ff <= fsp_pkg::SETTING_RESET;
    else if (loadStrobe)
      setting_ff <= arrRdData;
    else if (settingCommit)
      setting_ff <= candidate;
  end

  assign protectSetting = setting_ff;

  // ---------------------------------------------------------------
  // command check
  // ---------------------------------------------------------------
  logic cmdTaken;
  logic addrProtected;
  logic massAllowed;
  logic alters;
  logic refuse;
  logic violate;
  logic cmdGrant_ff;
  logic cmdDeny_ff;
  logic viol_ff;

  assign cmdReady = loaded;
  assign cmdTaken = cmdValid & loaded;

  fsp_prot_check u_check
  (
    .protMask(curMask),
    .addr(cmdReq.addr),
    .protectedHit(addrProtected)
  );

  assign massAllowed = setting_ff.protectPolaritySelect &
    setting_ff.upperRangeDisable & setting_ff.lowerRangeDisable;

  always_comb
  begin
    alters = 1'b0;
    violate = 1'b0;
    unique case (cmdReq.kind)
      fsp_pkg::CMD_PROGRAM, fsp_pkg::CMD_SECTOR_ERASE:
      begin
        alters = 1'b1;
        violate = addrProtected;
      end
      fsp_pkg::CMD_MASS_ERASE:
      begin
        alters = 1'b1;
        violate = ~massAllowed;
      end
      fsp_pkg::CMD_OTHER:
      begin
        alters = 1'b0;
        violate = 1'b0;
      end
    endcase
  end

  // an outstanding violation blocks every launch
  assign refuse = viol_ff | (alters & violate);

  // grant pulse, one cycle per accepted command
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cmdGrant_ff <= 1'b0;
    else
      cmdGrant_ff <= cmdTaken & ~refuse;
  end

  // deny pulse; the flag itself is kept in its own section
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cmdDeny_ff <= 1'b0;
    else
      cmdDeny_ff <= cmdTaken & refuse;
  end

  assign cmdGrant = cmdGrant_ff;
  assign cmdDeny = cmdDeny_ff;

  // ---------------------------------------------------------------
  // violation flag
  // ---------------------------------------------------------------
  logic violSet;
  logic violClear;
  logic nxt_viol;

  assign violSet = cmdTaken & ~viol_ff & alters & violate;
  assign violClear = busWrite & hitStatus & avsByteEnable[0] &
    avsWriteData[fsp_pkg::STAT_VIOL_BIT];

  // set needs the flag clear, so a violation in the cycle that clears a set flag is denied but lost
  always_comb
  begin
    nxt_viol = viol_ff;
    if (violClear)
      nxt_viol = 1'b0;
    if (violSet)
      nxt_viol = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      viol_ff <= 1'b0;
    else
      viol_ff <= nxt_viol;
  end

  assign protectViolation = viol_ff;

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] statusWord;
  logic [31:0] rdMux;
  logic [31:0] rdata_ff;

  // status bits other than flag and load done read zero
  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[fsp_pkg::STAT_VIOL_BIT] = viol_ff;
    statusWord[fsp_pkg::STAT_LOADED_BIT] = loaded;
  end

  always_comb
  begin
    rdMux = 32'h0000_0000;
    if (hitSetting)
      rdMux[7:0] = setting_ff;
    else if (hitStatus)
      rdMux = statusWord;
  end

  // unmapped addresses read zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rdata_ff <= fsp_pkg::RDATA_RESET;
    else if (busRead && loaded)
      rdata_ff <= rdMux;
  end

  assign avsReadData = rdata_ff;

endmodule

// >>> testbench/fsp_far_model.sv
// Purpose: command controller stand-in and nonvolatile byte source
// Assumes: bench holds go for one cycle per command
// Notes: idle read data is inverted so a stale byte cannot pass
`timescale 1ns/10ps
module fsp_far_model
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic go,
  input wire fsp_pkg::fsp_cmd_type goReq,
  input wire logic [7:0] nvByte,
  input wire logic cmdReady,
  input wire logic arrRdReq,
  output logic cmdValid,
  output fsp_pkg::fsp_cmd_type cmdReq,
  output logic arrRdValid,
  output logic [7:0] arrRdData
);
  logic [2:0] dly_ff;
  // ------------------------------
  // slow array answer, one launch per go
  // ------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dly_ff <= 3'h0;
      arrRdValid <= 1'b0;
      arrRdData <= 8'h00;
      cmdValid <= 1'b0;
      cmdReq <= '0;
    end
    else
    begin
      dly_ff <= dly_ff + 3'h1;
      arrRdValid <= arrRdReq && dly_ff == 3'h5;
      arrRdData <= (dly_ff == 3'h5) ? nvByte : ~nvByte;
      cmdValid <= go && cmdReady;
      cmdReq <= go ? goReq : ~cmdReq;
    end
  end
endmodule

// >>> testbench/fsp_checker.sv
// Purpose: port-level properties of the protection block
// Assumes: one clock, async active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/10ps
module fsp_checker
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  input wire logic arrRdReq,
  input wire logic [7:0] arrRdData,
  input wire logic arrRdValid,
  input wire logic cmdValid,
  input wire fsp_pkg::fsp_cmd_type cmdReq,
  input wire logic cmdReady,
  input wire logic cmdDeny,
  input wire fsp_pkg::fsp_setting_type protectSetting,
  input wire logic protectViolation
);
  wire take = cmdValid && cmdReady;
  wire run = cmdReady && rstn;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // ------------------------------
  // properties
  // ------------------------------
  property p_load;
    arrRdReq && arrRdValid |=> cmdReady && protectSetting == $past(arrRdData);
  endproperty
  a_load: assert property (p_load) else $error("load lost");
  property p_pol;
    run && $past(run) |-> !$rose(protectSetting[7]);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity rose");
  property p_lo;
    run && $past(run) && !$past(protectSetting[2])
      |-> $stable(protectSetting[1:0]);
  endproperty
  a_lo: assert property (p_lo) else $error("lower size moved");
  property p_hi;
    run && $past(run) && !$past(protectSetting[5])
      |-> $stable(protectSetting[4:3]);
  endproperty
  a_hi: assert property (p_hi) else $error("upper size moved");
  property p_rd;
    avsRead && !avsWaitRequest && avsAddress == fsp_pkg::ADDR_SETTING
      |-> avsReadData == {24'h0, protectSetting};
  endproperty
  a_rd: assert property (p_rd) else $error("setting read");
  property p_blk;
    take && protectViolation |=> cmdDeny;
  endproperty
  a_blk: assert property (p_blk) else $error("launch not blocked");
  property p_clr;
    avsWrite && !avsWaitRequest && avsAddress == fsp_pkg::ADDR_STATUS
      && avsWriteData[0] && !cmdValid |=> !protectViolation;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_mass;
    take && cmdReq.kind == fsp_pkg::CMD_MASS_ERASE && !(protectSetting[7]
      && protectSetting[5] && protectSetting[2]) |=> cmdDeny && protectViolation;
  endproperty
  a_mass: assert property (p_mass) else $error("mass erase");
  c_deny: cover property (cmdDeny && protectViolation);
  c_load: cover property (arrRdReq && arrRdValid);
  c_wr: cover property (avsWrite && !avsWaitRequest);
endmodule
bind flash_sector_protection fsp_checker u_chk (.*);

// >>> testbench/flash_sector_protection_tb_top.sv
// Purpose: self-checking bench for the flash sector protection block
// Assumes: far model launches commands, bench drives the register bus
// Notes: each result pops the oldest expectation; waits give up at 60
`timescale 1ns/10ps
module flash_sector_protection_tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic go = 1'b0;
  logic [3:0] avsAddress = 4'h0;
  logic [3:0] avsByteEnable = 4'hF;
  logic [31:0] avsWriteData = 32'h0;
  logic [7:0] nvByte = 8'hFF;
  fsp_pkg::fsp_cmd_type goReq = '0;
  logic avsWaitRequest, arrRdReq, arrRdValid, cmdValid, cmdReady;
  logic cmdGrant, cmdDeny, protectViolation;
  logic [31:0] avsReadData;
  logic [15:0] arrRdAddr;
  logic [7:0] arrRdData;
  fsp_pkg::fsp_cmd_type cmdReq;
  fsp_pkg::fsp_setting_type protectSetting;
  int miscompares = 0;
  int n_checks = 0;
  int seed = 39;
  logic [31:0] rdQ[$];
  logic cmdQ[$];
  flash_sector_protection u_dut (.*);
  fsp_far_model u_far (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic bit seen(input int k);
    case (k)
      0: seen = avsWaitRequest === 1'b0;
      1: seen = cmdReady === 1'b1;
      default: seen = (cmdGrant | cmdDeny) === 1'b1;
    endcase
  endfunction
  task automatic till(input int k);
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (!seen(k) && n < 60);
    miscompares += int'(!seen(k));
    if (!seen(k))
      test_done();
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    avsAddress <= a;
    avsWriteData <= {24'h0, d};
    avsWrite <= w;
    avsRead <= !w;
    till(0);
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rdQ.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask
  task automatic wrRd(input logic [7:0] w, e);
    bus(1'b1, fsp_pkg::ADDR_SETTING, w);
    rd(fsp_pkg::ADDR_SETTING, e);
  endtask
  task automatic cmd(input logic [1:0] k, input logic [15:0] a, input logic g);
    cmdQ.push_back(g);
    go <= 1'b1;
    goReq <= {k, a};
    @(posedge sys_clk);
    go <= 1'b0;
    till(2);
  endtask
  // refused command, then flag blocks, ignores zero, clears on one
  task automatic den(input logic [1:0] k, input logic [15:0] a);
    cmd(k, a, 1'b0);
    cmd(2'h3, a, 1'b0);
    bus(1'b1, fsp_pkg::ADDR_STATUS, 8'h00);
    rd(fsp_pkg::ADDR_STATUS, 8'h03);
    bus(1'b1, fsp_pkg::ADDR_STATUS, 8'h01);
    rd(fsp_pkg::ADDR_STATUS, 8'h02);
  endtask
  task automatic boot(input logic [7:0] nv);
    rstn <= 1'b0;
    nvByte <= nv;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    till(1);
    chk("nvaddr", 32'(arrRdAddr), 32'(fsp_pkg::NV_PROT_ADDR));
    rd(fsp_pkg::ADDR_SETTING, nv);
  endtask
  always @(posedge sys_clk)
  begin
    if (avsRead && seen(0))
      chk("rdata", avsReadData, rdQ.pop_front());
    if (seen(2))
    begin
      chk("deny", 32'(cmdDeny), 32'(!cmdQ[0]));
      chk("grant", 32'(cmdGrant), 32'(cmdQ.pop_front()));
    end
  end
  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    boot(8'hFF);
    avsByteEnable <= 4'hE;
    wrRd(8'h00, 8'hFF);
    avsByteEnable <= 4'hF;
    rd(4'h0, 8'h00);
    rd(fsp_pkg::ADDR_STATUS, 8'h02);
    cmd(2'h2, 16'h0000, 1'b1);
    cmd(2'h0, 16'hFF0D, 1'b1);
    wrRd(8'hFE, 8'hFE);
    wrRd(8'hFA, 8'hFA);
    wrRd(8'hF9, 8'hFA);
    wrRd(8'hFE, 8'hFA);
    den(2'h2, 16'h0000);
    den(2'h1, 16'h4FFF);
    cmd(2'h0, 16'h5000, 1'b1);
    wrRd(8'hDA, 8'hDA);
    den(2'h0, 16'hFF0D);
    cmd(2'h3, 16'hFF0D, 1'b1);
    for (int c = 0; c < 4; c++)
    begin
      boot(8'hC0 | 8'(c * 9));
      den(2'h0, 16'hFFFF << (11 + c));
      cmd(2'h1, ~(16'hFFFF << (11 + c)), 1'b1);
      den(2'h1, 16'h43FF + (16'h400 << c) - 16'h400);
      cmd(2'h0, 16'h4000 + (16'h400 << c), 1'b1);
    end
    boot(8'hFF);
    wrRd(8'h7F, 8'h7F);
    wrRd(8'hFF, 8'h7F);
    repeat (6) den(2'h0, 16'($random(seed)));
    boot(8'h5F);
    den(2'h0, 16'hBFFF);
    den(2'h2, 16'h0000);
    repeat (6) cmd(2'h0, 16'hC000 | 16'($random(seed)), 1'b1);
    test_done();
  end
endmodule
